// >>> design/pirs_consts.vh
`ifndef PIRS_CONSTS_VH
`define PIRS_CONSTS_VH
// ----------------------------------------
// serial register map
// ----------------------------------------
`define PIRS_ADDR_SETPOINT 8'h06
`define PIRS_ADDR_FLAGS 8'h0f
`define PIRS_FLAG_COMM_SP 1
`define PIRS_REG_RESET 16'h0000
// ----------------------------------------
// mode encodings
// ----------------------------------------
`define PIRS_DIFF_FUNC 8'h10
`define PIRS_MODE_OFF 2'h0
`define PIRS_MODE_PI 2'h1
`define PIRS_MODE_TRIM 2'h2
`define PIRS_LOSS_ALARM 2'h1
`define PIRS_LOSS_COAST 2'h2
`define PIRS_SLP_SPEED 2'h0
`define PIRS_SLP_SUM 2'h1
`define PIRS_SLP_SNOOZE 2'h2
`define PIRS_SP_PRESET 1'h1
`define PIRS_DIR_REVERSE 1'h1
`define PIRS_SQRT_ON 1'h1
// ----------------------------------------
// monitor scaling
// ----------------------------------------
`define PIRS_SCALE_HZ 16'h0000
`define PIRS_SCALE_PCT 16'h0001
`define PIRS_SCALE_POLES_MAX 16'h0027
`define PIRS_PCT_FULL 16'h2710
`define PIRS_ENG_MOD 16'h2710
`define PIRS_RPM_NUM 32'h00000006
`define PIRS_RPM_DEN 16'h0005
// ----------------------------------------
// arithmetic and timing
// ----------------------------------------
`define PIRS_FULL 16'hffff
`define PIRS_GAIN_FRAC 4
`define PIRS_I_SHIFT 4
`define PIRS_SQRT_SCALE 8
`define PIRS_SQRT_TOP 3'h7
`define PIRS_TICK_US 1000
`define PIRS_CLK_MHZ 10
`endif

// >>> design/pirs_sqrt.v
`include "pirs_consts.vh"
module pirs_sqrt (
	input wire sys_clk,
	input wire sys_rst,
	input wire [15:0] radicand,
	output reg [7:0] root_ff
);
	reg [15:0] x_ff;
	reg [7:0] res_ff;
	reg [2:0] bit_ff;
	wire [7:0] trial = res_ff | (8'h01 << bit_ff);
	wire [15:0] trial_sq = trial * trial;
	wire [7:0] nxt_res = (trial_sq <= x_ff) ? trial : res_ff;
	// ----------------------------------------
	// bit-serial root, one result per 8 cycles
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			x_ff <= 16'h0000;
			res_ff <= 8'h00;
			bit_ff <= `PIRS_SQRT_TOP;
			root_ff <= 8'h00;
		end else if (bit_ff == 3'h0) begin
			root_ff <= nxt_res;
			res_ff <= 8'h00;
			x_ff <= radicand;
			bit_ff <= `PIRS_SQRT_TOP;
		end else begin
			res_ff <= nxt_res;
			bit_ff <= bit_ff - 3'h1;
		end
	end
endmodule

// >>> design/pirs_timer.v
module pirs_timer (
	input wire sys_clk,
	input wire sys_rst,
	input wire tick,
	input wire cond,
	input wire [15:0] limit,
	output reg done_ff
);
	reg [15:0] cnt_ff;
	// ----------------------------------------
	// qualified delay, restarts when cond drops
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst || !cond) begin // [RULE23]
			cnt_ff <= 16'h0000;
			done_ff <= 1'b0;
		end else begin
			if (tick && cnt_ff < limit)
				cnt_ff <= cnt_ff + 16'h0001;
			done_ff <= (cnt_ff >= limit);
		end
	end
endmodule

// >>> design/pirs_regulator.v
// Summary of operation
// [RULE1] integral term clamped to programmable limit
// [RULE2] total output saturated at output limit; code clamps PI sum only, before offset, filter and gain
// [RULE3] offset added to output every update outside differential mode
// [RULE4] differential mode holds input difference at offset
// [RULE5] first-order lag filter on regulator output
// [RULE6] direction select one gives reverse acting
// [RULE7] output multiplied by programmable output gain
// [RULE8] loss select one: indicate only, keep running
// [RULE9] loss select two: coast, fault relay on
// [RULE10] loss after feedback low for detection time
// [RULE11] sleep when source low for delay time
// [RULE12] wake when source high for delay time
// [RULE13] sleep source: speed, sum, or snooze
// [RULE14] ramp applied to speed command and setpoint
// [RULE15] setpoint from preset, serial word, or speed
// [RULE16] differential mode ignores setpoint selection
// [RULE17] monitors scaled in Hz, percent, rpm, units
// [RULE18] snooze when output low for snooze delay
// [RULE19] snooze wake by feedback, not output
// [RULE20] boost setpoint before snooze, bounded time
// [RULE21] snooze when feedback above snooze level
// [RULE22] optional scaled square root of feedback
// [RULE23] timers count tick, restart when condition false
`include "pirs_consts.vh"
module pirs_regulator #(
	parameter [23:0] TICK_CYCLES = `PIRS_TICK_US * `PIRS_CLK_MHZ
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata_ff,
	input wire [15:0] first_analog_input,
	input wire [15:0] second_analog_input,
	input wire [15:0] speed_command,
	input wire [15:0] max_frequency,
	input wire [1:0] regulator_mode,
	input wire [7:0] second_input_function,
	input wire [15:0] integral_limit,
	input wire [15:0] output_limit,
	input wire [15:0] output_offset,
	input wire [3:0] lag_time_constant,
	input wire acting_direction_select,
	input wire [7:0] output_gain,
	input wire [1:0] feedback_loss_select,
	input wire [15:0] feedback_loss_level,
	input wire [15:0] feedback_loss_time,
	input wire [15:0] sleep_start_level,
	input wire [15:0] sleep_delay_time,
	input wire [1:0] sleep_source_select,
	input wire [3:0] reference_ramp_time,
	input wire setpoint_source_select,
	input wire [15:0] preset_setpoint,
	input wire [15:0] monitor_scaling,
	input wire [15:0] snooze_level,
	input wire [15:0] snooze_delay_time,
	input wire [15:0] snooze_wake_level,
	input wire [15:0] setpoint_boost,
	input wire [15:0] max_boost_time,
	input wire [15:0] snooze_feedback_level,
	input wire sqrt_feedback_enable,
	input wire [7:0] sqrt_gain,
	input wire sqrt_output_monitor_select,
	output reg [15:0] speed_output_ff,
	output reg drive_run_ff,
	output reg loss_output_ff,
	output reg fault_relay_output_ff,
	output reg [15:0] setpoint_monitor_ff,
	output reg [15:0] feedback_monitor_ff,
	output reg [15:0] output_monitor_ff
);
	localparam ST_RUN = 2'h0;
	localparam ST_SLEEP = 2'h1;
	localparam ST_BOOST = 2'h2;
	localparam ST_SNOOZE = 2'h3;

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	function signed [19:0] clamp_sym;
		input signed [19:0] v;
		input [15:0] lim;
		reg signed [19:0] l;
		begin
			l = $signed({4'h0, lim});
			if (v > l)
				clamp_sym = l;
			else if (v < -l)
				clamp_sym = -l;
			else
				clamp_sym = v;
		end
	endfunction

	function [15:0] sat_u16;
		input signed [19:0] v;
		begin
			if (v < 20'sh0)
				sat_u16 = 16'h0000;
			else if (v > $signed({4'h0, `PIRS_FULL}))
				sat_u16 = `PIRS_FULL;
			else
				sat_u16 = v[15:0];
		end
	endfunction

	function signed [19:0] mul_gain;
		input signed [19:0] v;
		input [7:0] g;
		reg signed [28:0] p;
		begin
			p = v * $signed({1'b0, g});
			mul_gain = p[19+`PIRS_GAIN_FRAC:`PIRS_GAIN_FRAC];
		end
	endfunction

	function [15:0] ramp_to;
		input [15:0] cur;
		input [15:0] tgt;
		input [3:0] sh;
		reg [15:0] stp;
		begin
			stp = `PIRS_FULL >> sh;
			if (tgt > cur)
				ramp_to = (tgt - cur > stp) ? cur + stp : tgt;
			else
				ramp_to = (cur - tgt > stp) ? cur - stp : tgt;
		end
	endfunction

	function [15:0] mon_scale;
		input [15:0] v;
		input [15:0] s;
		input [15:0] fmax;
		reg [31:0] full;
		reg [31:0] p;
		begin
			if (s == `PIRS_SCALE_HZ)
				full = {16'h0000, fmax};
			else if (s == `PIRS_SCALE_PCT)
				full = {16'h0000, `PIRS_PCT_FULL};
			else if (s <= `PIRS_SCALE_POLES_MAX)
				full = ({16'h0000, fmax} * `PIRS_RPM_NUM) / ({16'h0000, s} * {16'h0000, `PIRS_RPM_DEN});
			else
				full = {16'h0000, s % `PIRS_ENG_MOD};
			p = {16'h0000, v} * {16'h0000, full[15:0]};
			mon_scale = p[31:16];
		end
	endfunction

	// ----------------------------------------
	// input synchronisers and tick
	// ----------------------------------------
	reg [15:0] ain1_meta_ff, ain1_ff, ain2_meta_ff, ain2_ff;
	reg [23:0] tick_cnt_ff;
	reg tick_ff;
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			ain1_meta_ff <= 16'h0000;
			ain1_ff <= 16'h0000;
			ain2_meta_ff <= 16'h0000;
			ain2_ff <= 16'h0000;
			tick_cnt_ff <= 24'h000000;
			tick_ff <= 1'b0;
		end else begin
			ain1_meta_ff <= first_analog_input;
			ain1_ff <= ain1_meta_ff;
			ain2_meta_ff <= second_analog_input;
			ain2_ff <= ain2_meta_ff;
			tick_ff <= (tick_cnt_ff == TICK_CYCLES - 24'h000001);
			tick_cnt_ff <= (tick_cnt_ff == TICK_CYCLES - 24'h000001) ? 24'h000000 : tick_cnt_ff + 24'h000001;
		end
	end

	// ----------------------------------------
	// serial registers
	// ----------------------------------------
	reg [15:0] comm_setpoint_word_ff, comm_select_flags_ff;
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			comm_setpoint_word_ff <= `PIRS_REG_RESET;
			comm_select_flags_ff <= `PIRS_REG_RESET;
			reg_rdata_ff <= 16'h0000;
		end else begin
			if (reg_wr_en && reg_addr == `PIRS_ADDR_SETPOINT)
				comm_setpoint_word_ff <= reg_wdata;
			else if (reg_wr_en && reg_addr == `PIRS_ADDR_FLAGS)
				comm_select_flags_ff <= reg_wdata;
			if (reg_rd_en) begin
				if (reg_addr == `PIRS_ADDR_SETPOINT)
					reg_rdata_ff <= comm_setpoint_word_ff;
				else if (reg_addr == `PIRS_ADDR_FLAGS)
					reg_rdata_ff <= comm_select_flags_ff;
				else
					reg_rdata_ff <= 16'h0000;
			end
		end
	end

	// ----------------------------------------
	// feedback and setpoint selection
	// ----------------------------------------
	reg [1:0] st_ff;
	reg [15:0] sp_ramp_ff, spd_ramp_ff;
	reg signed [19:0] integ_ff, filt_ff, pi_out_ff;
	wire [7:0] fb_root, out_root;
	wire diff_mode = (second_input_function == `PIRS_DIFF_FUNC);
	wire signed [19:0] fb_raw = diff_mode ? $signed({4'h0, ain1_ff}) - $signed({4'h0, ain2_ff}) // [RULE4]
		: $signed({4'h0, ain2_ff});
	wire signed [19:0] fb_sqrt = mul_gain($signed({4'h0, fb_root, 8'h00}), sqrt_gain);
	wire signed [19:0] fb_eff = (sqrt_feedback_enable == `PIRS_SQRT_ON) ? fb_sqrt : fb_raw; // [RULE22]
	wire [15:0] fb_pos = sat_u16(fb_eff);
	wire [15:0] sp_base = (setpoint_source_select == `PIRS_SP_PRESET) ? preset_setpoint // [RULE15]
		: comm_select_flags_ff[`PIRS_FLAG_COMM_SP] ? comm_setpoint_word_ff : spd_ramp_ff;
	wire [15:0] boost_sp = sat_u16($signed({4'h0, sp_base}) + $signed({4'h0, setpoint_boost}));
	wire [15:0] sp_target = diff_mode ? output_offset // [RULE16]
		: (st_ff == ST_BOOST) ? boost_sp : sp_base; // [RULE20]

	pirs_sqrt u_fb_sqrt (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.radicand(sat_u16(fb_raw)),
		.root_ff(fb_root)
	);
	pirs_sqrt u_out_sqrt (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.radicand(sat_u16(pi_out_ff)),
		.root_ff(out_root)
	);

	// ----------------------------------------
	// proportional-integral path
	// ----------------------------------------
	wire signed [19:0] err_fwd = $signed({4'h0, sp_ramp_ff}) - fb_eff;
	wire signed [19:0] err = (acting_direction_select == `PIRS_DIR_REVERSE) ? -err_fwd : err_fwd; // [RULE6]
	wire signed [19:0] nxt_integ = clamp_sym(integ_ff + err, integral_limit); // [RULE1]
	wire signed [19:0] pi_sum = clamp_sym(err + (nxt_integ >>> `PIRS_I_SHIFT), output_limit); // [RULE2]
	wire signed [19:0] pi_offs = diff_mode ? pi_sum : pi_sum + $signed({4'h0, output_offset}); // [RULE3]
	wire signed [19:0] nxt_filt = filt_ff + ((pi_offs - filt_ff) >>> lag_time_constant); // [RULE5]
	wire signed [19:0] nxt_pi = mul_gain(nxt_filt, output_gain); // [RULE7]
	wire [15:0] sum_cmd = sat_u16($signed({4'h0, spd_ramp_ff}) + pi_out_ff);
	wire [15:0] cmd = (regulator_mode == `PIRS_MODE_OFF) ? spd_ramp_ff
		: (regulator_mode == `PIRS_MODE_PI) ? sat_u16(pi_out_ff) : sum_cmd;
	wire reg_active = (regulator_mode != `PIRS_MODE_OFF) && (st_ff == ST_RUN || st_ff == ST_BOOST);

	// ----------------------------------------
	// supervision timers
	// ----------------------------------------
	wire snooze_sel = (sleep_source_select == `PIRS_SLP_SNOOZE);
	wire [15:0] sleep_src = (sleep_source_select == `PIRS_SLP_SUM) ? sum_cmd : spd_ramp_ff; // [RULE13]
	wire lost, sleep_done, wake_done, snooze_done, boost_done;
	pirs_timer u_loss (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tick(tick_ff),
		.cond(fb_pos < feedback_loss_level), // [RULE10]
		.limit(feedback_loss_time),
		.done_ff(lost)
	);
	pirs_timer u_sleep (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tick(tick_ff),
		.cond(st_ff == ST_RUN && !snooze_sel && sleep_src < sleep_start_level), // [RULE11]
		.limit(sleep_delay_time),
		.done_ff(sleep_done)
	);
	pirs_timer u_wake (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tick(tick_ff),
		.cond(st_ff == ST_SLEEP && sleep_src > sleep_start_level), // [RULE12]
		.limit(sleep_delay_time),
		.done_ff(wake_done)
	);
	pirs_timer u_snooze (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tick(tick_ff),
		.cond(st_ff == ST_RUN && snooze_sel && speed_output_ff < snooze_level), // [RULE18]
		.limit(snooze_delay_time),
		.done_ff(snooze_done)
	);
	pirs_timer u_boost (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tick(tick_ff),
		.cond(st_ff == ST_BOOST), // [RULE23]
		.limit(max_boost_time),
		.done_ff(boost_done)
	);

	// ----------------------------------------
	// sleep and snooze state machine
	// ----------------------------------------
	reg [1:0] nxt_st;
	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			ST_RUN: begin
				if (!snooze_sel && sleep_done)
					nxt_st = ST_SLEEP; // [RULE11]
				else if (snooze_sel && fb_pos > snooze_feedback_level)
					nxt_st = ST_SNOOZE; // [RULE21]
				else if (snooze_sel && snooze_done)
					nxt_st = ST_BOOST; // [RULE18]
			end
			ST_SLEEP: begin
				if (snooze_sel || wake_done)
					nxt_st = ST_RUN; // [RULE12]
			end
			ST_BOOST: begin
				if (fb_pos >= boost_sp || boost_done)
					nxt_st = ST_SNOOZE; // [RULE20]
			end
			default: begin
				if (fb_pos < snooze_wake_level)
					nxt_st = ST_RUN; // [RULE19]
			end
		endcase
	end

	// ----------------------------------------
	// regulator update and outputs
	// ----------------------------------------
	wire coast = (feedback_loss_select == `PIRS_LOSS_COAST) && lost; // [RULE9]
	wire run_state = (st_ff == ST_RUN || st_ff == ST_BOOST);
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			st_ff <= ST_RUN;
			sp_ramp_ff <= 16'h0000;
			spd_ramp_ff <= 16'h0000;
			integ_ff <= 20'sh0;
			filt_ff <= 20'sh0;
			pi_out_ff <= 20'sh0;
			speed_output_ff <= 16'h0000;
			drive_run_ff <= 1'b0;
			loss_output_ff <= 1'b0;
			fault_relay_output_ff <= 1'b0;
			setpoint_monitor_ff <= 16'h0000;
			feedback_monitor_ff <= 16'h0000;
			output_monitor_ff <= 16'h0000;
		end else begin
			st_ff <= nxt_st;
			loss_output_ff <= (feedback_loss_select != 2'h0) && lost; // [RULE8]
			fault_relay_output_ff <= coast; // [RULE9]
			drive_run_ff <= run_state && !coast;
			speed_output_ff <= (run_state && !coast) ? cmd : 16'h0000; // [RULE11]
			if (tick_ff) begin
				sp_ramp_ff <= ramp_to(sp_ramp_ff, sp_target, reference_ramp_time); // [RULE14]
				spd_ramp_ff <= ramp_to(spd_ramp_ff, speed_command, reference_ramp_time); // [RULE14]
				if (reg_active) begin
					integ_ff <= nxt_integ;
					filt_ff <= nxt_filt;
					pi_out_ff <= nxt_pi;
				end else begin
					integ_ff <= 20'sh0;
					filt_ff <= 20'sh0;
					pi_out_ff <= 20'sh0;
				end
				setpoint_monitor_ff <= mon_scale(sp_ramp_ff, monitor_scaling, max_frequency); // [RULE17]
				feedback_monitor_ff <= mon_scale(fb_pos, monitor_scaling, max_frequency); // [RULE17]
				output_monitor_ff <= sqrt_output_monitor_select ? {out_root, 8'h00} : sat_u16(pi_out_ff);
			end
		end
	end
endmodule

// >>> test/pirs_regulator_props.sv
module pirs_checker (
	input wire sys_clk,
	input wire sys_rst,
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata_ff,
	input wire [15:0] second_analog_input,
	input wire [15:0] feedback_loss_level,
	input wire [1:0] feedback_loss_select,
	input wire [15:0] speed_output_ff,
	input wire drive_run_ff,
	input wire loss_output_ff,
	input wire fault_relay_output_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	property p_fault_sel;
		(feedback_loss_select != 2'h2) [*2] |-> !fault_relay_output_ff;
	endproperty
	a_fault_sel: assert property (p_fault_sel) else $error("fault relay on without coast select");
	property p_fault_loss;
		fault_relay_output_ff |-> loss_output_ff;
	endproperty
	a_fault_loss: assert property (p_fault_loss) else $error("fault relay on without loss");
	property p_coast;
		fault_relay_output_ff |-> ##[0:3] (speed_output_ff == 16'h0000);
	endproperty
	a_coast: assert property (p_coast) else $error("output not removed on coast");
	property p_sleep_zero;
		$fell(drive_run_ff) |-> ##[0:2] (speed_output_ff == 16'h0000);
	endproperty
	a_sleep_zero: assert property (p_sleep_zero) else $error("output not stopped after run drop");
	property p_loss_low;
		$rose(loss_output_ff) |-> (feedback_loss_select != 2'h0) && ($past(second_analog_input, 4) < feedback_loss_level);
	endproperty
	a_loss_low: assert property (p_loss_low) else $error("loss raised without low feedback");
	property p_unmapped;
		reg_rd_en && (reg_addr != 8'h06) && (reg_addr != 8'h0f) |=> (reg_rdata_ff == 16'h0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	sequence s_wr_rd;
		(reg_wr_en && !reg_rd_en && reg_addr == 8'h06) ##1 (reg_rd_en && !reg_wr_en && reg_addr == 8'h06);
	endsequence
	property p_readback;
		s_wr_rd |=> (reg_rdata_ff == $past(reg_wdata, 2));
	endproperty
	a_readback: assert property (p_readback) else $error("setpoint word readback wrong");
	property p_stands;
		!reg_rd_en |=> $stable(reg_rdata_ff);
	endproperty
	a_stands: assert property (p_stands) else $error("read data changed without read");
	c_loss: cover property ($rose(loss_output_ff));
	c_fault: cover property ($rose(fault_relay_output_ff));
	c_sleep: cover property ($fell(drive_run_ff));
endmodule
bind pirs_regulator pirs_checker pirs_checker_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
	.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
	.second_analog_input(second_analog_input), .feedback_loss_level(feedback_loss_level),
	.feedback_loss_select(feedback_loss_select), .speed_output_ff(speed_output_ff), .drive_run_ff(drive_run_ff),
	.loss_output_ff(loss_output_ff), .fault_relay_output_ff(fault_relay_output_ff));

// >>> test/pirs_xducer.sv
// ----------------------------------------
// feedback transducer, slew limited
// ----------------------------------------
module pirs_xducer (
	input wire sys_clk,
	input wire [15:0] target,
	output logic [15:0] level
);
	timeunit 1ns;
	timeprecision 1ns;
	initial level = 16'h8000;
	always @(negedge sys_clk) begin
		if (target > level)
			level <= (target - level > 16'h1000) ? level + 16'h1000 : target;
		else
			level <= (level - target > 16'h1000) ? level - 16'h1000 : target;
	end
endmodule

// >>> test/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
	logic acting_direction_select = 1'b0, setpoint_source_select = 1'b0;
	logic sqrt_feedback_enable = 1'b0, sqrt_output_monitor_select = 1'b0;
	logic [1:0] regulator_mode = 2'h0, feedback_loss_select = 2'h0, sleep_source_select = 2'h0;
	logic [3:0] lag_time_constant = 4'h0, reference_ramp_time = 4'h0;
	logic [7:0] reg_addr = 8'h00, second_input_function = 8'h00, output_gain = 8'h10, sqrt_gain = 8'h10;
	logic [15:0] reg_wdata = 16'h0, first_analog_input = 16'h0, output_offset = 16'h0, snooze_level = 16'h0;
	logic [15:0] speed_command = 16'h8000, fb_target = 16'h8000, preset_setpoint = 16'h8000, max_frequency = 16'h1770;
	logic [15:0] integral_limit = 16'h4000, output_limit = 16'h4000, monitor_scaling = 16'h0, snooze_wake_level = 16'h0;
	logic [15:0] feedback_loss_level = 16'h1000, sleep_start_level = 16'h1000, snooze_feedback_level = 16'hffff;
	logic [15:0] feedback_loss_time = 16'h3, sleep_delay_time = 16'h3, snooze_delay_time = 16'h3;
	logic [15:0] setpoint_boost = 16'h0, max_boost_time = 16'h0;
	wire [15:0] second_analog_input, reg_rdata_ff, speed_output_ff;
	wire [15:0] setpoint_monitor_ff, feedback_monitor_ff, output_monitor_ff;
	wire drive_run_ff, loss_output_ff, fault_relay_output_ff;
	int fails = 0;
	int checks_done = 0;
	always #50 sys_clk = ~sys_clk;
	pirs_xducer pirs_xducer_inst (.sys_clk(sys_clk), .target(fb_target), .level(second_analog_input));
	pirs_regulator #(.TICK_CYCLES(24'd4)) pirs_regulator_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_ff(reg_rdata_ff), .first_analog_input(first_analog_input), .second_analog_input(second_analog_input),
		.speed_command(speed_command), .max_frequency(max_frequency), .regulator_mode(regulator_mode),
		.second_input_function(second_input_function), .integral_limit(integral_limit), .output_limit(output_limit),
		.output_offset(output_offset), .lag_time_constant(lag_time_constant),
		.acting_direction_select(acting_direction_select), .output_gain(output_gain),
		.feedback_loss_select(feedback_loss_select), .feedback_loss_level(feedback_loss_level),
		.feedback_loss_time(feedback_loss_time), .sleep_start_level(sleep_start_level),
		.sleep_delay_time(sleep_delay_time), .sleep_source_select(sleep_source_select),
		.reference_ramp_time(reference_ramp_time), .setpoint_source_select(setpoint_source_select),
		.preset_setpoint(preset_setpoint), .monitor_scaling(monitor_scaling), .snooze_level(snooze_level),
		.snooze_delay_time(snooze_delay_time), .snooze_wake_level(snooze_wake_level), .setpoint_boost(setpoint_boost),
		.max_boost_time(max_boost_time), .snooze_feedback_level(snooze_feedback_level),
		.sqrt_feedback_enable(sqrt_feedback_enable), .sqrt_gain(sqrt_gain),
		.sqrt_output_monitor_select(sqrt_output_monitor_select), .speed_output_ff(speed_output_ff),
		.drive_run_ff(drive_run_ff), .loss_output_ff(loss_output_ff), .fault_relay_output_ff(fault_relay_output_ff),
		.setpoint_monitor_ff(setpoint_monitor_ff), .feedback_monitor_ff(feedback_monitor_ff),
		.output_monitor_ff(output_monitor_ff));
	// ----------------------------------------
	// compare, wait and bus tasks
	// ----------------------------------------
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check1(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask
	task check16(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	function logic pick(input int sel, input logic [15:0] goal);
		case (sel)
			0: pick = drive_run_ff;
			1: pick = loss_output_ff;
			2: pick = fault_relay_output_ff;
			default: pick = (speed_output_ff === goal);
		endcase
	endfunction
	task wait_bit(input int sel, input logic val, input string name, input logic [15:0] goal = 16'h0);
		int n;
		n = 0;
		while (pick(sel, goal) !== val && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		if (pick(sel, goal) !== val) begin
			$display("mismatch %s timed out", name);
			fails++;
			tally_and_finish();
		end
		else
			check1(name, val, pick(sel, goal));
	endtask
	task reg_write(input logic [7:0] addr, input logic [15:0] data);
		reg_rd_en = 1'b0;
		reg_wr_en = 1'b1;
		reg_addr = addr;
		reg_wdata = data;
		@(negedge sys_clk);
	endtask
	task reg_read(input logic [7:0] addr, input logic [15:0] exp);
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b1;
		reg_addr = addr;
		@(negedge sys_clk);
		check16("reg_rdata_ff", exp, reg_rdata_ff);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		reg_read(8'h06, 16'h0000);
		reg_read(8'h0f, 16'h0000);
		reg_write(8'h06, 16'h1234);
		reg_read(8'h06, 16'h1234);
		reg_write(8'h0f, 16'h0002);
		reg_read(8'h0f, 16'h0002);
		reg_read(8'h20, 16'h0000);
		reg_rd_en = 1'b0;
		$display("test regs done");
	endtask
	task t_ramp;
		reference_ramp_time = 4'h4;
		speed_command = 16'ha000;
		repeat (2) @(negedge sys_clk);
		check1("speed_output_ff settled early", 1'b0, speed_output_ff === 16'ha000);
		wait_bit(3, 1'b1, "speed_output_ff", 16'ha000);
		reference_ramp_time = 4'h0;
		speed_command = 16'h8000;
		wait_bit(3, 1'b1, "speed_output_ff", 16'h8000);
		$display("test ramp done");
	endtask
	task t_sleep;
		speed_command = 16'h0800;
		repeat (6) @(negedge sys_clk);
		check1("drive_run_ff early", 1'b1, drive_run_ff);
		wait_bit(0, 1'b0, "drive_run_ff");
		check16("speed_output_ff", 16'h0000, speed_output_ff);
		speed_command = 16'h8000;
		repeat (6) @(negedge sys_clk);
		check1("drive_run_ff early wake", 1'b0, drive_run_ff);
		wait_bit(0, 1'b1, "drive_run_ff");
		wait_bit(3, 1'b1, "speed_output_ff", 16'h8000);
		$display("test sleep done");
	endtask
	task t_loss;
		feedback_loss_select = 2'h1;
		fb_target = 16'h0000;
		repeat (6) @(negedge sys_clk);
		check1("loss_output_ff early", 1'b0, loss_output_ff);
		wait_bit(1, 1'b1, "loss_output_ff");
		check1("fault_relay_output_ff", 1'b0, fault_relay_output_ff);
		check1("drive_run_ff", 1'b1, drive_run_ff);
		fb_target = 16'h8000;
		wait_bit(1, 1'b0, "loss_output_ff");
		feedback_loss_select = 2'h2;
		fb_target = 16'h0000;
		wait_bit(2, 1'b1, "fault_relay_output_ff");
		check1("loss_output_ff", 1'b1, loss_output_ff);
		wait_bit(3, 1'b1, "speed_output_ff", 16'h0000);
		fb_target = 16'h8000;
		wait_bit(2, 1'b0, "fault_relay_output_ff");
		feedback_loss_select = 2'h0;
		wait_bit(3, 1'b1, "speed_output_ff", 16'h8000);
		$display("test loss done");
	endtask
	task t_snooze;
		snooze_wake_level = 16'h4000;
		snooze_feedback_level = 16'hc000;
		sleep_source_select = 2'h2;
		fb_target = 16'hf000;
		wait_bit(0, 1'b0, "drive_run_ff");
		check16("speed_output_ff", 16'h0000, speed_output_ff);
		fb_target = 16'h2000;
		wait_bit(0, 1'b1, "drive_run_ff");
		sleep_source_select = 2'h0;
		snooze_feedback_level = 16'hffff;
		fb_target = 16'h8000;
		$display("test snooze done");
	endtask
	task t_pi;
		monitor_scaling = 16'h0001;
		setpoint_source_select = 1'b1;
		output_offset = 16'h1000;
		output_limit = 16'h0100;
		fb_target = 16'h7000;
		repeat (8) @(negedge sys_clk);
		regulator_mode = 2'h1;
		wait_bit(3, 1'b1, "speed_output_ff", 16'h1100);
		repeat (8) @(negedge sys_clk);
		check16("setpoint_monitor_ff", 16'h1388, setpoint_monitor_ff);
		check16("feedback_monitor_ff", 16'h1117, feedback_monitor_ff);
		check16("output_monitor_ff", 16'h1100, output_monitor_ff);
		acting_direction_select = 1'b1;
		wait_bit(3, 1'b1, "speed_output_ff", 16'h0f00);
		output_gain = 8'h20;
		wait_bit(3, 1'b1, "speed_output_ff", 16'h1e00);
		acting_direction_select = 1'b0;
		output_gain = 8'h10;
		output_offset = 16'h0000;
		output_limit = 16'h4000;
		integral_limit = 16'h0100;
		wait_bit(3, 1'b1, "speed_output_ff", 16'h1010);
		lag_time_constant = 4'h2;
		output_offset = 16'h0400;
		repeat (6) @(negedge sys_clk);
		check1("speed_output_ff unfiltered", 1'b0, speed_output_ff === 16'h1410);
		lag_time_constant = 4'h0;
		wait_bit(3, 1'b1, "speed_output_ff", 16'h1410);
		second_input_function = 8'h10;
		first_analog_input = 16'h8000;
		output_offset = 16'h1800;
		wait_bit(3, 1'b1, "speed_output_ff", 16'h0810);
		sqrt_feedback_enable = 1'b1;
		output_offset = 16'h4400;
		wait_bit(3, 1'b1, "speed_output_ff", 16'h0410);
		$display("test pi done");
	endtask
	initial begin
		repeat (8) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_regs();
		t_ramp();
		t_sleep();
		t_loss();
		t_snooze();
		t_pi();
		tally_and_finish();
	end
endmodule
